// [rtl/bmc_mode_ctrl.sv]
// Burst level detection, burst operation and auto-restart sequencing with APB registers.
//
// Summary of operation
// [R1] Burst entry threshold 1.60, 1.42 or 1.27 V follows the detected level.
// [R2] In burst, peak limit drops to 0.45, 0.37 or 0.31 V by level.
// [R3] Smallest capacitor level: burst never entered, reduced limit always selected.
// [R4] Level detection runs once, first 1 ms after first supply release only.
// [R5] Detection waits while brownout or other protection is active before start-up.
// [R6] At 4.5 V count and discharge; at 0.5 V recharge; repeat until window ends.
// [R7] At window end the count picks and latches the burst level.
// [R8] Blanking counter zero normally; feedback below entry for 20 ms enters burst.
// [R9] Burst entry sets the burst flag and turns bias off.
// [R10] In burst, feedback above 3.5 V restores bias and switching at reduced limit.
// [R11] In burst, feedback down to 3.2 V turns bias off again.
// [R12] Feedback above 4.0 V leaves burst and restores the full current limit.
// [R13] Odd-skip: odd cycles idle and unchecked; even cycles check faults and switch.
// [R14] Odd-skip returns to normal only on a fault-free even cycle.
// [R15] Odd-skip non-switch: no switching at all; fault cleared on even cycle resumes.
// [R16] Supply over 20.5 V with high feedback in soft start, or 25.5 V: odd-skip.
// [R17] Feedback above 4.5 V for 20 ms then 256 blanking cycles: odd-skip.
// [R18] Brownout lasting 30 us enters non-switch restart.
// [R19] After overload blanking, a 30 us spike blank precedes odd-skip restart.
// [R20] Restart parity toggles on each supply release, cleared when back to normal.
// [R21] Every comparator input passes a two-stage synchroniser before use.
//
// Limitation: levels and limits are only selected here; the comparators,
// switches and current sources sit in the analog part.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps

module bmc_mode_ctrl
    import bmc_pkg::*;
#(
    parameter int DETECT_CYC = `BMC_DETECT_NS / `BMC_CLK_NS,
    parameter int BLANK_CYC = `BMC_BLANK_NS / `BMC_CLK_NS,
    parameter int SPIKE_CYC = `BMC_SPIKE_NS / `BMC_CLK_NS,
    parameter int BROWNOUT_CYC = `BMC_BROWNOUT_NS / `BMC_CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bmc_cmp_t cmp_in,
    output bmc_drv_t drv
);

    bmc_state_t r;
    bmc_state_t n;
    bmc_cmp_t c;
    bmc_status_t st;
    logic [1:0] lvl;
    logic rise;
    logic ss_end;
    logic fd_en;
    logic burst_cond;
    logic ovl_cond;
    logic blank_done;
    logic ovl_done;
    logic ovl_trip;
    logic bo_trip;
    logic ovp;
    logic run_even;
    logic setup;
    logic wr;
    logic hit;

    // All state is one packed struct, so reset and capture share one process.
    // A counter that must hold reloads its own value through the copy n.

    // Only the second stage is read by the block's logic.
    // The first stage gets a full period to settle, so nothing taps it.
    assign c = r.s2; // [R21]
    assign rise = c.supply_ok && !r.lock_prev;
    assign ss_end = r.ss_prev && !c.soft_start;
    assign lvl = r.ctrl.ovr_en ? r.ctrl.ovr_lvl : r.level;
    assign run_even = r.cyc_on && !r.parity && c.supply_ok;

    // Parity 1 marks an odd cycle; a cycle must have begun to count as even.

    // Fault detection runs in normal and burst operation and on even odd-skip cycles.
    assign fd_en = (r.mode == MD_NORMAL) || (r.mode == MD_BURST)
        || ((r.mode == MD_ODD_SKIP) && run_even); // [R13]
    assign burst_cond = (r.mode == MD_NORMAL) && c.fb_burst && r.ctrl.burst_en
        && (lvl != `BMC_LVL_NEVER); // [R3]
    assign ovl_cond = fd_en && c.fb_hi;
    assign blank_done = r.blank_cnt == bmc_tmr_t'(BLANK_CYC - 1);
    assign ovl_done = r.ovl_cnt == `BMC_OVL_CYCLES;
    assign ovl_trip = ovl_done && (r.spike_cnt == bmc_tmr_t'(SPIKE_CYC - 1)); // [R19]
    assign bo_trip = r.bo_cnt == bmc_tmr_t'(BROWNOUT_CYC - 1); // [R18]
    assign ovp = c.vcc_ovp2 || (c.vcc_ovp1 && c.fb_hi && c.soft_start); // [R16]

    // Overvoltage has no filter: a late trip lets the supply rise further.
    // The comparators carry their own hysteresis.

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign hit = (paddr == `BMC_OFF_CTRL) || (paddr == `BMC_OFF_STATUS)
        || (paddr == `BMC_OFF_COUNT) || (paddr == `BMC_OFF_THRESH);

    // A gap in the map reads zero and drops writes.

    // Reserved status bits read zero, so software may compare whole words.
    // The reduced-limit bit mirrors the pin, not a stored copy.
    always_comb begin
        st = '0;
        st.mode = r.mode;
        st.level = lvl;
        st.burst_flag = r.burst_flag;
        st.bias_on = r.bias_on;
        st.parity = r.parity;
        st.detect_done = r.detect_done;
        st.reduced = drv.reduced_limit_en;
    end

    always_comb begin
        n = r;
        n.s1 = cmp_in; // [R21]
        n.s2 = r.s1; // [R21]
        n.lock_prev = c.supply_ok;
        n.ss_prev = c.soft_start;

        // Edge detectors reset to zero, the idle level of their inputs,
        // so no false edge follows reset.

        // Shared blanking timer: burst entry and overload never hold at once.
        // It stops at its last count, so blank_done holds.
        if (!(burst_cond || ovl_cond)) begin
            n.blank_cnt = '0; // [R8]
        end else if (!blank_done) begin
            n.blank_cnt = r.blank_cnt + bmc_tmr_t'(1); // [R8]
        end

        // Extended overload blanking on the blanking capacitor.
        // One count per discharge and recharge; feedback dropping below
        // the overload level abandons the whole sequence.
        if (!ovl_cond) begin
            n.ext_on = 1'b0;
            n.bba_dis = 1'b0;
            n.ovl_cnt = '0;
            n.spike_cnt = '0;
        end else if (blank_done && !r.ext_on) begin
            n.ext_on = 1'b1; // [R17]
            n.bba_dis = 1'b1;
        end else if (r.ext_on && !ovl_done) begin
            if (r.bba_dis && c.bba_lo) begin
                n.bba_dis = 1'b0;
            end else if (!r.bba_dis && c.bba_hi) begin
                n.bba_dis = 1'b1;
                n.ovl_cnt = r.ovl_cnt + 9'h001; // [R17]
            end
        end else if (ovl_done && !ovl_trip) begin
            n.spike_cnt = r.spike_cnt + bmc_tmr_t'(1); // [R19]
        end

        // Brownout persistence filter.
        // The lower bound of the window is used so no real brownout is missed.
        // Shorter glitches are ignored.
        if (!(fd_en && c.brownout)) begin
            n.bo_cnt = '0;
        end else if (!bo_trip) begin
            n.bo_cnt = r.bo_cnt + bmc_tmr_t'(1); // [R18]
        end

        // A restart cycle begins at each supply release and ends when it drops.
        // Parity counts releases only inside a restart mode.
        if (!c.supply_ok) begin
            n.cyc_on = 1'b0;
        end else if (rise) begin
            n.cyc_on = 1'b1;
        end
        if (rise && (r.mode inside {MD_ODD_SKIP, MD_ODD_SKIP_NS, MD_NON_SWITCH})) begin
            n.parity = !r.parity; // [R20]
        end

        // Mode steps come first; the fault block below may override them.
        // Each mode keeps its own exit so priorities stay visible.

        unique case (r.mode)
            MD_POWERUP: begin
                // Protection pending before start-up holds detection back.
                // A later release after detection goes straight to normal.
                if (c.supply_ok && !c.brownout && !c.ext_protect) begin
                    if (r.detect_done) begin
                        n.mode = MD_NORMAL; // [R4]
                    end else begin
                        n.mode = MD_DETECT; // [R5]
                        n.win_cnt = '0;
                        n.det_cnt = '0;
                        n.dis_latch = 1'b0;
                    end
                end
            end

            MD_DETECT: begin
                n.win_cnt = r.win_cnt + bmc_tmr_t'(1);
                if (!r.dis_latch && c.fb_hi) begin
                    n.dis_latch = 1'b1; // [R6]
                    // The count saturates, so a tiny capacitor never
                    // aliases to a large one.
                    if (r.det_cnt != '1) begin
                        n.det_cnt = r.det_cnt + bmc_cnt_t'(1); // [R6]
                    end
                end else if (r.dis_latch && c.fb_lo) begin
                    n.dis_latch = 1'b0; // [R6]
                end
                // The window runs from entry, so a postponed detection
                // still gets its full length.
                if (r.win_cnt == bmc_tmr_t'(DETECT_CYC - 1)) begin
                    // Large capacitor charges slowly, so few cycles mean the high level.
                    if (r.det_cnt < bmc_cnt_t'(r.thresh.lim_hi)) begin
                        n.level = `BMC_LVL_HI; // [R7]
                    end else if (r.det_cnt < bmc_cnt_t'(r.thresh.lim_mid)) begin
                        n.level = `BMC_LVL_MID; // [R7]
                    end else if (r.det_cnt < bmc_cnt_t'(r.thresh.lim_lo)) begin
                        n.level = `BMC_LVL_LO; // [R7]
                    end else begin
                        n.level = `BMC_LVL_NEVER; // [R7]
                    end
                    n.detect_done = 1'b1; // [R4]
                    n.dis_latch = 1'b0;
                    n.mode = MD_NORMAL;
                    n.bias_on = 1'b1;
                end
            end

            MD_NORMAL: begin
                // Flag, bias and mode change on the same edge.
                if (burst_cond && blank_done) begin
                    n.mode = MD_BURST; // [R8]
                    n.burst_flag = 1'b1; // [R9]
                    n.bias_on = 1'b0; // [R9]
                end
            end

            MD_BURST: begin
                // Exit outranks wake and wake outranks sleep, since the
                // comparator levels nest.
                if (c.fb_exit) begin
                    n.mode = MD_NORMAL; // [R12]
                    n.burst_flag = 1'b0; // [R12]
                    n.bias_on = 1'b1;
                end else if (c.fb_wake) begin
                    n.bias_on = 1'b1; // [R10]
                end else if (c.fb_sleep) begin
                    n.bias_on = 1'b0; // [R11]
                end
            end

            MD_ODD_SKIP: begin
                // Leaving at soft start end gives the even cycle
                // its full fault check first.
                if (run_even && ss_end) begin
                    n.mode = MD_NORMAL; // [R14]
                end
            end

            MD_ODD_SKIP_NS: begin
                // Switching stays off; fault detection is off too, and only overtemperature is checked on even cycles.
                if (run_even && !c.overtemp) begin
                    n.mode = MD_NORMAL; // [R15]
                end
            end

            MD_NON_SWITCH: begin
                // Any started cycle with the cause gone resumes.
                if (r.cyc_on && c.supply_ok && !c.brownout && !c.ext_protect) begin
                    n.mode = MD_NORMAL;
                end
            end
        endcase

        // A return from any restart mode restores bias and clears parity.
        if (n.mode == MD_NORMAL && r.mode != MD_NORMAL && r.mode != MD_BURST) begin
            n.parity = 1'b0; // [R20]
            n.bias_on = 1'b1;
            n.burst_flag = 1'b0;
        end

        // Faults outrank every mode step above; a new trip restarts the parity.
        // Overtemperature wins: its restart never switches, the safe choice.
        // All timers restart so the next even cycle counts afresh.
        if (fd_en && (c.overtemp || ovp || ovl_trip || bo_trip || c.ext_protect)) begin
            if (c.overtemp) begin
                n.mode = MD_ODD_SKIP_NS;
            end else if (ovp || ovl_trip) begin
                n.mode = MD_ODD_SKIP; // [R16] [R17]
            end else begin
                n.mode = MD_NON_SWITCH; // [R18]
            end
            n.parity = 1'b0;
            n.cyc_on = 1'b0;
            n.burst_flag = 1'b0;
            n.bias_on = 1'b0;
            n.blank_cnt = '0;
            n.ext_on = 1'b0;
            n.bba_dis = 1'b0;
            n.ovl_cnt = '0;
            n.spike_cnt = '0;
            n.bo_cnt = '0;
        end

        // Register access: write at the access edge, read data captured in setup.
        // Capturing in setup keeps prdata a plain register output.
        if (wr && paddr == `BMC_OFF_CTRL) begin
            n.ctrl = bmc_ctrl_t'(pwdata);
            n.ctrl.rsvd = '0;
        end
        if (wr && paddr == `BMC_OFF_THRESH) begin
            n.thresh = bmc_thresh_t'(pwdata);
            n.thresh.rsvd = '0;
        end
        if (setup) begin
            unique case (paddr)
                `BMC_OFF_CTRL: n.prdata = r.ctrl;
                `BMC_OFF_STATUS: n.prdata = st;
                `BMC_OFF_COUNT: n.prdata = {{(32 - `BMC_CNT_W){1'b0}}, r.det_cnt};
                `BMC_OFF_THRESH: n.prdata = r.thresh;
                default: n.prdata = '0;
            endcase
        end
    end

    // Reset zeroes every field except the mode, the level, which reads
    // as never until detection has run, and the two registers.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.mode <= MD_POWERUP;
            r.level <= `BMC_LVL_NEVER;
            r.ctrl <= `BMC_CTRL_RST;
            r.thresh <= `BMC_THRESH_RST;
        end else begin
            r <= n;
        end
    end

    // The slave never stretches a transfer, so pready is tied high.

    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        // Threshold and limit pins share one code, so they never disagree.

        drv.entry_sel = lvl; // [R1]
        drv.limit_sel = lvl; // [R2]
        drv.reduced_limit_en = r.burst_flag || (lvl == `BMC_LVL_NEVER); // [R2] [R3]
        drv.bias_on = r.bias_on;
        drv.burst_flag = r.burst_flag;
        // Switching in burst only while bias is up; odd-skip switches on even cycles only.
        drv.switch_en = c.supply_ok && ((r.mode == MD_NORMAL)
            || ((r.mode == MD_BURST) && r.bias_on) // [R10]
            || ((r.mode == MD_ODD_SKIP) && run_even)); // [R13] [R15]

        // The discharge switch follows its latch directly, free of glitches; the blanking pins also gate on ovl_done.
        drv.detect_discharge_switch = r.dis_latch; // [R6]
        drv.bba_charge_en = r.ext_on && !r.bba_dis && !ovl_done;
        drv.bba_discharge_en = r.ext_on && r.bba_dis && !ovl_done;
    end

endmodule

// [rtl/bmc_defines.svh]
// Constants of the burst and restart mode controller: offsets, reset values, timing.
`ifndef BMC_DEFINES_SVH
`define BMC_DEFINES_SVH

// Clock period and documented times, in nanoseconds.
`define BMC_CLK_NS 4
`define BMC_DETECT_NS 1000000
`define BMC_BLANK_NS 20000000
`define BMC_SPIKE_NS 30000
`define BMC_BROWNOUT_NS 30000

// Extended overload blanking charge/discharge cycles.
`define BMC_OVL_CYCLES 9'h100

// Widths of timers and of the detection cycle counter.
`define BMC_TMR_W 24
`define BMC_CNT_W 16

// Register byte offsets on the APB.
`define BMC_OFF_CTRL 12'h000
`define BMC_OFF_STATUS 12'h004
`define BMC_OFF_COUNT 12'h008
`define BMC_OFF_THRESH 12'h00c

// Register reset values.
`define BMC_CTRL_RST 32'h0000_0001
`define BMC_THRESH_RST 32'h0040_1004

// Burst level codes: entry threshold 1.60 V, 1.42 V, 1.27 V, never.
`define BMC_LVL_HI 2'h0
`define BMC_LVL_MID 2'h1
`define BMC_LVL_LO 2'h2
`define BMC_LVL_NEVER 2'h3

`endif

// [rtl/bmc_pkg.sv]
// Types of the burst and restart mode controller.
package bmc_pkg;
`include "bmc_defines.svh"

typedef logic [`BMC_TMR_W-1:0] bmc_tmr_t;
typedef logic [`BMC_CNT_W-1:0] bmc_cnt_t;

typedef enum logic [2:0] {
    MD_POWERUP, MD_DETECT, MD_NORMAL, MD_BURST, MD_ODD_SKIP, MD_ODD_SKIP_NS, MD_NON_SWITCH
} bmc_mode_t;

// Comparator and supply flags arriving from the analog side.
typedef struct packed {
    logic fb_hi;       // Feedback above 4.5 V.
    logic fb_lo;       // Feedback below 0.5 V.
    logic fb_burst;    // Feedback below the selected burst entry threshold.
    logic fb_wake;     // Feedback above 3.5 V.
    logic fb_sleep;    // Feedback below 3.2 V.
    logic fb_exit;     // Feedback above 4.0 V.
    logic bba_hi;      // Blanking capacitor above 4.5 V.
    logic bba_lo;      // Blanking capacitor below 0.9 V.
    logic vcc_ovp1;    // Supply above 20.5 V.
    logic vcc_ovp2;    // Supply above 25.5 V.
    logic brownout;
    logic ext_protect;
    logic overtemp;
    logic supply_ok;   // Supply lockout released.
    logic soft_start;
} bmc_cmp_t;

// Drive signals toward the analog side.
typedef struct packed {
    logic [1:0] entry_sel;
    logic [1:0] limit_sel;
    logic reduced_limit_en;
    logic bias_on;
    logic switch_en;
    logic burst_flag;
    logic detect_discharge_switch;
    logic bba_charge_en;
    logic bba_discharge_en;
} bmc_drv_t;

typedef struct packed {
    logic [27:0] rsvd;
    logic [1:0] ovr_lvl;
    logic ovr_en;
    logic burst_en;
} bmc_ctrl_t;

typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] lim_lo;
    logic [7:0] lim_mid;
    logic [7:0] lim_hi;
} bmc_thresh_t;

typedef struct packed {
    logic [21:0] rsvd;
    logic reduced;
    logic detect_done;
    logic parity;
    logic bias_on;
    logic burst_flag;
    logic [1:0] level;
    bmc_mode_t mode;
} bmc_status_t;

typedef struct packed {
    bmc_cmp_t s1;
    bmc_cmp_t s2;
    logic lock_prev;
    logic ss_prev;
    bmc_mode_t mode;
    logic detect_done;
    logic dis_latch;
    bmc_cnt_t det_cnt;
    bmc_tmr_t win_cnt;
    bmc_tmr_t blank_cnt;
    logic ext_on;
    logic bba_dis;
    logic [8:0] ovl_cnt;
    bmc_tmr_t spike_cnt;
    bmc_tmr_t bo_cnt;
    logic [1:0] level;
    logic burst_flag;
    logic bias_on;
    logic parity;
    logic cyc_on;
    bmc_ctrl_t ctrl;
    bmc_thresh_t thresh;
    logic [31:0] prdata;
} bmc_state_t;

endpackage

// [tb/bmc_mode_ctrl_monitor.sv]
// Concurrent checks on the ports of the mode controller.
`timescale 1ns/10ps
module bmc_mode_ctrl_monitor
    import bmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire bmc_cmp_t cmp_in,
    input wire bmc_drv_t drv
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_ready_a: assert property (pready)
        else $error("pready low");
    apb_err_a: assert property (psel && penable |->
        pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
        else $error("pslverr wrong for address");
    never_burst_a: assert property (
        drv.entry_sel == 2'h3 |-> drv.reduced_limit_en && !drv.burst_flag)
        else $error("level three must not burst");
    burst_limit_a: assert property (
        drv.burst_flag |-> drv.reduced_limit_en && drv.limit_sel == drv.entry_sel)
        else $error("burst limit not reduced");
    burst_entry_a: assert property (
        $rose(drv.burst_flag) |-> !drv.bias_on && !drv.switch_en)
        else $error("bias still on at burst entry");
    burst_leave_a: assert property (
        $fell(drv.burst_flag) |-> $past(cmp_in.fb_exit, 3)
        && (drv.entry_sel == 2'h3 || !drv.reduced_limit_en))
        else $error("burst left without exit cause");
    sleep_quiet_a: assert property (
        drv.burst_flag && !drv.bias_on |-> !drv.switch_en)
        else $error("switching while bias off");
    wake_sync_a: assert property (
        $rose(drv.bias_on) && drv.burst_flag |-> $past(cmp_in.fb_wake, 3))
        else $error("bias on without wake");
    detect_dis_a: assert property (
        $rose(drv.detect_discharge_switch) |-> $past(cmp_in.fb_hi, 3))
        else $error("discharge without high feedback");
endmodule

bind bmc_mode_ctrl bmc_mode_ctrl_monitor bmc_mode_ctrl_monitor_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_in(cmp_in), .drv(drv));

// [tb/bmc_flyback_model.sv]
// Behavioural power stage: feedback and blanking capacitor ramps.
`timescale 1ns/10ps
module bmc_flyback_model
    import bmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire bmc_drv_t drv,
    input wire logic load_hi,
    input wire logic cap_en,
    input wire logic [3:0] rc_len,
    output logic fb_hi,
    output logic fb_lo,
    output logic bba_hi,
    output logic bba_lo
);
    logic [3:0] fbv, bbv;
    // One step a clock; rc_len stands for the RC time, so changing it varies the count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fbv <= 4'h0;
            bbv <= 4'h0;
        end else begin
            if (drv.detect_discharge_switch) fbv <= (fbv == 4'h0) ? fbv : fbv - 4'h1;
            else fbv <= (fbv >= rc_len) ? fbv : fbv + 4'h1;
            if (drv.bba_discharge_en) bbv <= (bbv == 4'h0) ? bbv : bbv - 4'h1;
            else if (drv.bba_charge_en) bbv <= (bbv >= rc_len) ? bbv : bbv + 4'h1;
        end
    end
    assign fb_hi = load_hi | (cap_en & (fbv >= rc_len));
    assign fb_lo = !load_hi & (fbv == 4'h0);
    assign bba_hi = bbv >= rc_len;
    assign bba_lo = bbv == 4'h0;
endmodule

// [tb/tb_bmc_mode_ctrl.sv]
// Self-checking bench of the burst and restart mode controller.
`timescale 1ns/10ps
module tb_bmc_mode_ctrl;
    import bmc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic load_hi = 1'b0, cap_en = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] rc_len = 4'h4;
    logic [31:0] prdata, e, m;
    logic pready, pslverr, m_fb_hi, m_fb_lo, m_bba_hi, m_bba_lo;
    bmc_cmp_t cin = '0;
    bmc_cmp_t cmp_in, f;
    bmc_drv_t drv;
    logic [31:0] exp_q[$], msk_q[$];
    int bad_count = 0, n_checks = 0;
    int bit_t[5] = '{5, 2, 4, 3, 0};
    int hold_t[5] = '{20, 20, 20, 20, 7000};
    logic [2:0] md_t[5] = '{3'h4, 3'h5, 3'h6, 3'h6, 3'h4};
    logic [3:0] dv_t[3] = '{4'hf, 4'ha, 4'h5};
    logic [4:0] sw_t = 5'b10001, early_t = 5'b00001;
    initial begin
        forever #2 pclk = ~pclk;
    end
    always_comb begin
        cmp_in = cin;
        cmp_in.fb_hi = m_fb_hi;
        cmp_in.fb_lo = m_fb_lo;
        cmp_in.bba_hi = m_bba_hi;
        cmp_in.bba_lo = m_bba_lo;
    end
    bmc_mode_ctrl #(.DETECT_CYC(64), .BLANK_CYC(32), .SPIKE_CYC(8), .BROWNOUT_CYC(8))
        bmc_mode_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_in(cmp_in), .drv(drv));
    bmc_flyback_model bmc_flyback_model_i (.pclk(pclk), .presetn(presetn), .drv(drv),
        .load_hi(load_hi), .cap_en(cap_en), .rc_len(rc_len), .fb_hi(m_fb_hi),
        .fb_lo(m_fb_lo), .bba_hi(m_bba_hi), .bba_lo(m_bba_lo));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] mk);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) begin
            exp_q.push_back(d);
            msk_q.push_back(mk);
        end
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] md);
        apb(1'b0, 12'h004, {29'h0, md}, 32'h7);
    endtask
    task automatic dv(input logic [3:0] x);
        chk({28'h0, drv.burst_flag, drv.bias_on, drv.reduced_limit_en, drv.switch_en}, {28'h0, x});
    endtask
    task automatic pulse(input int b);
        cin <= bmc_cmp_t'(cin | (15'h1 << b));
        wt(6);
        cin <= bmc_cmp_t'(cin & ~(15'h1 << b));
        wt(6);
    endtask
    task automatic cyc(input int n);
        repeat (n) begin
            cin.supply_ok <= 1'b0;
            wt(8);
            cin.supply_ok <= 1'b1;
            wt(8);
        end
    endtask
    task automatic fault(input int k);
        f = (k == 4) ? bmc_cmp_t'(15'h0) : bmc_cmp_t'(15'h1 << bit_t[k]);
        cin <= bmc_cmp_t'(cin | f);
        load_hi <= (k == 4);
        wt(hold_t[k]);
        rd(md_t[k]);
        if (early_t[k]) begin
            cin <= bmc_cmp_t'(cin & ~f);
            wt(1);
        end
        cyc(1);
        chk({31'h0, drv.switch_en}, 32'h0);
        cyc(1);
        chk({31'h0, drv.switch_en}, {31'h0, sw_t[k]});
        rd(md_t[k]);
        cin <= bmc_cmp_t'(cin & ~f);
        load_hi <= 1'b0;
        wt(1);
        cyc(2);
        pulse(0);
        rd(3'h2);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk(prdata & m, e & m);
            chk({31'h0, pslverr}, {31'h0, paddr > 12'h00c});
        end
    end
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
    initial begin
        void'($urandom(89));
        wt(4);
        dv(4'b0010);
        chk({28'h0, drv.entry_sel, drv.limit_sel}, 32'hf);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h1, '1);
        apb(1'b0, 12'h00c, 32'h0040_1004, '1);
        apb(1'b0, 12'h010, 32'h0, '1);
        apb(1'b1, 12'h00c, 32'h00c8_0201, '0);
        apb(1'b0, 12'h00c, 32'h00c8_0201, '1);
        cin.brownout <= 1'b1;
        wt(1);
        cin.supply_ok <= 1'b1;
        wt(20);
        rd(3'h0);
        cin.brownout <= 1'b0;
        cap_en <= 1'b1;
        repeat (66) begin
            @(posedge pclk);
            rc_len <= 4'h3 + 4'($urandom % 4);
        end
        cap_en <= 1'b0;
        wt(4);
        apb(1'b0, 12'h004, 32'h0000_0152, 32'h0000_015f);
        chk({28'h0, drv.entry_sel, drv.limit_sel}, 32'ha);
        dv(4'b0101);
        cin.fb_burst <= 1'b1;
        wt(20);
        cin.fb_burst <= 1'b0;
        wt(30);
        dv(4'b0101);
        cin.fb_burst <= 1'b1;
        wt(45);
        cin.fb_burst <= 1'b0;
        dv(4'b1010);
        chk({30'h0, drv.limit_sel}, 32'h2);
        rd(3'h3);
        for (int i = 0; i < 3; i++) begin
            pulse(11 - i);
            dv(dv_t[i]);
        end
        rd(3'h2);
        apb(1'b1, 12'h000, 32'hf, '0);
        cin.fb_burst <= 1'b1;
        wt(45);
        cin.fb_burst <= 1'b0;
        dv(4'b0111);
        chk({30'h0, drv.entry_sel}, 32'h3);
        apb(1'b1, 12'h000, 32'h1, '0);
        cin.brownout <= 1'b1;
        wt(4);
        cin.brownout <= 1'b0;
        wt(10);
        rd(3'h2);
        for (int k = 0; k < 5; k++) begin
            fault(k);
        end
        summarize();
    end
endmodule
